//--- hdl/iox_bus_if.sv
// Purpose: open-drain SCL/SDA wires between master and expander
// Assumes: pull-ups modelled as a released line reading high
// Notes:   a driver pulls low when its enable is high and its data is low
`timescale 1ns/10ps
interface iox_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  assign scl = (m_scl_oe & ~m_scl_o) ? 1'b0 : 1'b1;
  assign sda = ((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o)) ? 1'b0 : 1'b1;

  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

//--- hdl/iox_master.sv
// Purpose: AHB-Lite controlled serial master that drives the expander link
// Assumes: no clock stretching by the slave; single word transfers only
// Notes:   zero wait state slave; one transaction at a time, go ignored if busy
//
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`include "iox_params.svh"
module iox_master
  import iox_pkg::*;
#(
  parameter int SCL_PERIOD_NS = `IOX_SCL_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  iox_bus_if.master        bus
);

  localparam int QTR = (SCL_PERIOD_NS / `IOX_HCLK_PERIOD_NS) / 4;

  // Device side oversamples the link, so each quarter needs some cycles
  if (QTR < 8 || QTR > 65536) begin : g_chk
    $error("SCL_PERIOD_NS outside the range of the quarter-bit divider");
  end

  // ------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------
  logic       take;
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic [6:0] sla;
  logic [7:0] cmdb;
  logic [7:0] data;
  logic       mode_rd;
  logic       mode_dir;
  logic       busy;
  logic       nack;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      wr_pend   <= take & hwrite;
      wr_addr   <= haddr[7:0];
      hrdata    <= 32'h00000000;
      if (take && !hwrite) begin
        case (haddr[7:0])
          `IOX_REG_SLA:  hrdata <= {25'h0000000, sla};
          `IOX_REG_CMD:  hrdata <= {24'h000000, cmdb};
          `IOX_REG_DATA: hrdata <= {24'h000000, data};
          `IOX_REG_CTRL: hrdata <= {29'h00000000, mode_dir, mode_rd, 1'b0};
          `IOX_REG_STAT: hrdata <= {30'h00000000, nack, busy};
          default:       hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  logic go;

  assign go = wr_pend & (wr_addr == `IOX_REG_CTRL) & hwdata[`IOX_CTL_GO] & ~busy;

  // ------------------------------------------------------------
  // Link synchroniser and quarter-bit divider
  // ------------------------------------------------------------
  logic [1:0] sda_m;
  logic       sda_s;
  logic [15:0] qcnt;
  logic        tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_m <= 2'b11;
    end else begin
      sda_m <= {sda_m[0], bus.sda};
    end
  end

  assign sda_s = sda_m[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt <= 16'h0000;
      tick <= 1'b0;
    end else if (qcnt == 16'(QTR - 1)) begin
      qcnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      qcnt <= qcnt + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Transfer engine
  // ------------------------------------------------------------
  iox_mst_t   st;
  iox_step_t  step;
  logic [1:0] q;
  logic [3:0] bitn;
  logic [7:0] txsh;
  logic [7:0] rxsh;
  logic       scl_low;
  logic       sda_low;

  function automatic logic [7:0] byte_for(input iox_step_t s, input logic [6:0] a,
                                          input logic [7:0] c, input logic [7:0] d);
    case (s)
      ST_AW:   byte_for = {a, 1'b0};                      // see (R09)
      ST_CMD:  byte_for = c;
      ST_DATA: byte_for = d;
      ST_AR:   byte_for = {a, 1'b1};                      // see (R12)
      default: byte_for = 8'hFF;
    endcase
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sla      <= 7'h00;
      cmdb     <= 8'h00;
      data     <= 8'h00;
      mode_rd  <= 1'b0;
      mode_dir <= 1'b0;
      busy     <= 1'b0;
      nack     <= 1'b0;
      st       <= MS_IDLE;
      step     <= ST_AW;
      q        <= 2'b00;
      bitn     <= 4'h0;
      txsh     <= 8'h00;
      rxsh     <= 8'h00;
      scl_low  <= 1'b0;
      sda_low  <= 1'b0;
    end else if (go) begin
      mode_rd  <= hwdata[`IOX_CTL_RD];
      mode_dir <= hwdata[`IOX_CTL_DIRECT];
      busy     <= 1'b1;
      nack     <= 1'b0;
      st       <= MS_START;                               // see (R04)
      q        <= 2'b00;
      step     <= hwdata[`IOX_CTL_DIRECT] ? ST_AR : ST_AW;
    end else if (wr_pend && !busy) begin
      case (wr_addr)
        `IOX_REG_SLA:  sla  <= hwdata[6:0];
        `IOX_REG_CMD:  cmdb <= hwdata[7:0];
        `IOX_REG_DATA: data <= hwdata[7:0];
        default: ;
      endcase
    end else if (tick && st != MS_IDLE) begin
      q <= q + 2'b01;
      case (st)
        MS_START, MS_RSTART: begin
          case (q)
            2'd0: sda_low <= 1'b0;
            2'd1: if (st == MS_START) sda_low <= 1'b1; else scl_low <= 1'b0;
            2'd2: if (st == MS_START) scl_low <= 1'b1; else sda_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              st      <= MS_BIT;
              bitn    <= 4'h0;
              txsh    <= byte_for(step, sla, cmdb, data);
            end
          endcase
        end
        MS_BIT: begin
          case (q)
            2'd0: sda_low <= (bitn < `IOX_BYTE_BITS) ? ~txsh[7] : 1'b0;  // see (R05)
            2'd1: scl_low <= 1'b0;
            2'd2: begin
              if (bitn < `IOX_BYTE_BITS) begin
                rxsh <= {rxsh[6:0], sda_s};
              end else if (step != ST_RD && sda_s) begin
                nack <= 1'b1;
              end
            end
            default: begin
              scl_low <= 1'b1;
              txsh    <= {txsh[6:0], 1'b1};
              bitn    <= bitn + 4'h1;
              if (bitn == `IOX_BYTE_BITS) begin
                bitn <= 4'h0;
                if (nack) begin
                  st <= MS_STOP;                          // see (R17)
                end else begin
                  case (step)
                    ST_AW: begin
                      step <= ST_CMD;
                      txsh <= cmdb;
                    end
                    ST_CMD: begin
                      if (mode_rd) begin
                        step <= ST_AR;
                        st   <= MS_RSTART;                // see (R12)
                      end else begin
                        step <= ST_DATA;
                        txsh <= data;                     // see (R11)
                      end
                    end
                    ST_AR: begin
                      step <= ST_RD;
                      txsh <= 8'hFF;
                    end
                    ST_RD: begin
                      data <= rxsh;                       // see (R14)
                      st   <= MS_STOP;
                    end
                    default: st <= MS_STOP;               // see (R11)
                  endcase
                end
              end
            end
          endcase
        end
        MS_STOP: begin
          case (q)
            2'd0: sda_low <= 1'b1;
            2'd1: scl_low <= 1'b0;
            2'd2: sda_low <= 1'b0;
            default: begin
              busy <= 1'b0;
              st   <= MS_IDLE;
            end
          endcase
        end
        default: st <= MS_IDLE;
      endcase
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_low;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_low;

endmodule

//--- hdl/iox_params.svh
// Purpose: shared constants of the port expander serial slave and its bus master
// Assumes: one clock hclk at 125 MHz, SCL made by the master end from hclk
// Notes:   byte offsets of the master's AHB-Lite registers are word aligned
//
// Summary of operation
// (R01) Hold reset until supply crosses rising threshold
// (R02) New reset only after supply drops below falling threshold
// (R03) After reset, accept a bus request anytime
// (R04) Master starts only on an idle bus
// (R05) SDA stable while SCL high, MSB first, ACK
// (R06) Strap low answers address 0x20
// (R07) Strap high answers address 0x21
// (R08) Address LSB one reads, zero writes
// (R09) Write: START, address with W, command byte
// (R10) Slave acknowledges the command byte
// (R11) Data bytes follow, STOP closes the write
// (R12) Read: write command, repeated START, address with R
// (R13) Slave acknowledges read address, then transmits bytes
// (R14) Master ACKs wanted bytes, NACKs the last, STOP
// (R15) NACK after a byte releases SDA
// (R16) Command bytes offered during a read get NACK
// (R17) STOP may end any transfer; last acked data holds
// (R18) Command byte kept; direct read uses it
// (R19) First write byte is the command, codes 00-03
// (R20) Input register reads pins, ignores writes
// (R21) Config one is input, zero output, default ones
// (R22) Polarity bit set inverts reported input
// (R23) Later write bytes acked and stored to selected register
// (R24) Ignore foreign addresses; START or STOP resets sequencer
`ifndef IOX_PARAMS_SVH
`define IOX_PARAMS_SVH

// ------------------------------------------------------------
// Serial slave
// ------------------------------------------------------------
`define IOX_ADDR_HI        6'h10
`define IOX_BYTE_BITS      4'h8
`define IOX_CMD_RST        8'h00
`define IOX_CMD_IN         8'h00
`define IOX_CMD_OUT        8'h01
`define IOX_CMD_POL        8'h02
`define IOX_CMD_CFG        8'h03
`define IOX_OUT_RST        8'hFF
`define IOX_POL_RST        8'h00
`define IOX_CFG_RST        8'hFF

// ------------------------------------------------------------
// Master registers and timing
// ------------------------------------------------------------
`define IOX_REG_SLA        8'h00
`define IOX_REG_CMD        8'h04
`define IOX_REG_DATA       8'h08
`define IOX_REG_CTRL       8'h0C
`define IOX_REG_STAT       8'h10
`define IOX_CTL_GO         0
`define IOX_CTL_RD         1
`define IOX_CTL_DIRECT     2
`define IOX_STAT_BUSY      0
`define IOX_STAT_NACK      1
`define IOX_SCL_PERIOD_NS  2500
`define IOX_HCLK_PERIOD_NS 8

`endif

//--- hdl/iox_pkg.sv
// Purpose: types shared by both ends of the expander link
// Assumes: constants come from iox_params.svh
// Notes:   state codes are left to the tools
package iox_pkg;
  typedef enum logic [2:0] {SS_IDLE, SS_ADDR, SS_AACK, SS_WR, SS_WACK, SS_RD, SS_RACK} iox_sst_t;
  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BIT, MS_RSTART, MS_STOP} iox_mst_t;
  typedef enum logic [2:0] {ST_AW, ST_CMD, ST_DATA, ST_AR, ST_RD} iox_step_t;
endpackage

//--- hdl/iox_slave.sv
// Purpose: serial slave and register file of the 8-bit port expander
// Assumes: SCL far slower than hclk; supply comparators arrive as levels
// Notes:   SCL and SDA are oversampled, so edges are seen two cycles late
`timescale 1ns/10ps
`include "iox_params.svh"
module iox_slave
  import iox_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  iox_bus_if.slave        bus,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  input  wire logic       addr_strap,
  input  wire logic       port_supply_above_rise,
  input  wire logic       port_supply_below_fall
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [12:0] meta;
  logic [12:0] sync;
  logic [7:0]  pins_now;
  logic        scl_s;
  logic        sda_s;
  logic        strap_s;
  logic        above_s;
  logic        below_s;
  logic        scl_d;
  logic        sda_d;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Link bits start at their idle high level so no false edge follows reset
      meta <= {8'h00, 2'b11, 3'b000};
      sync <= {8'h00, 2'b11, 3'b000};
    end else begin
      meta <= {pin_in, bus.scl, bus.sda, addr_strap, port_supply_above_rise,
               port_supply_below_fall};
      sync <= meta;
    end
  end

  assign pins_now = sync[12:5];
  assign scl_s    = sync[4];
  assign sda_s    = sync[3];
  assign strap_s  = sync[2];
  assign above_s  = sync[1];
  assign below_s  = sync[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  // ------------------------------------------------------------
  // Power-on reset
  // ------------------------------------------------------------
  // Hysteresis: release needs the rising threshold, re-arm needs the falling one
  logic por_hold;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_hold <= 1'b1;
    end else if (below_s) begin
      por_hold <= 1'b1;                                   // see (R02)
    end else if (above_s) begin
      por_hold <= 1'b0;                                   // see (R01)
    end
  end

  // ------------------------------------------------------------
  // Registers and read selection
  // ------------------------------------------------------------
  logic [7:0] cmd;
  logic [7:0] out_reg;
  logic [7:0] pol_reg;
  logic [7:0] cfg_reg;
  logic [7:0] reg_rd;

  always_comb begin
    case (cmd)
      `IOX_CMD_IN:  reg_rd = pins_now ^ pol_reg;          // see (R20) see (R22)
      `IOX_CMD_OUT: reg_rd = out_reg;
      `IOX_CMD_POL: reg_rd = pol_reg;
      `IOX_CMD_CFG: reg_rd = cfg_reg;
      default:      reg_rd = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Serial sequencer
  // ------------------------------------------------------------
  iox_sst_t   st;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic       rw;
  logic       first;
  logic       ack_in;
  logic       drv;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st      <= SS_IDLE;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      txsh    <= 8'h00;
      rw      <= 1'b0;
      first   <= 1'b0;
      ack_in  <= 1'b0;
      drv     <= 1'b0;
      cmd     <= `IOX_CMD_RST;
      out_reg <= `IOX_OUT_RST;
      pol_reg <= `IOX_POL_RST;
      cfg_reg <= `IOX_CFG_RST;
    end else if (por_hold) begin
      st      <= SS_IDLE;                                 // see (R01)
      bitcnt  <= 4'h0;
      drv     <= 1'b0;
      first   <= 1'b0;
      cmd     <= `IOX_CMD_RST;
      out_reg <= `IOX_OUT_RST;
      pol_reg <= `IOX_POL_RST;
      cfg_reg <= `IOX_CFG_RST;                            // see (R21)
    end else if (start_seen) begin
      st     <= SS_ADDR;                                  // see (R24) see (R03)
      bitcnt <= 4'h0;
      drv    <= 1'b0;
    end else if (stop_seen) begin
      st     <= SS_IDLE;                                  // see (R24) see (R17)
      drv    <= 1'b0;
    end else if (scl_rise) begin
      case (st)
        SS_ADDR, SS_WR: begin
          shreg  <= {shreg[6:0], sda_s};                  // see (R05)
          bitcnt <= bitcnt + 4'h1;
        end
        SS_RACK: ack_in <= ~sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (st)
        SS_ADDR: begin
          if (bitcnt == `IOX_BYTE_BITS) begin
            // Strap supplies the bit just above direction
            if (shreg[7:1] == {`IOX_ADDR_HI, strap_s}) begin  // see (R06) see (R07)
              rw  <= shreg[0];                            // see (R08)
              drv <= 1'b1;
              st  <= SS_AACK;
            end else begin
              st <= SS_IDLE;                              // see (R24)
            end
          end
        end
        SS_AACK: begin
          first  <= 1'b1;
          bitcnt <= 4'h0;
          if (rw) begin
            // In a read this end only transmits, so offered bytes go unacked
            txsh   <= {reg_rd[6:0], 1'b0};                // see (R13) see (R18) see (R16)
            drv    <= ~reg_rd[7];
            bitcnt <= 4'h1;
            st     <= SS_RD;
          end else begin
            drv <= 1'b0;
            st  <= SS_WR;
          end
        end
        SS_WR: begin
          if (bitcnt == `IOX_BYTE_BITS) begin
            drv   <= 1'b1;                                // see (R10) see (R23)
            st    <= SS_WACK;
            first <= 1'b0;
            if (first) begin
              cmd <= shreg;                               // see (R19)
            end else begin
              case (cmd)
                `IOX_CMD_OUT: out_reg <= shreg;           // see (R23)
                `IOX_CMD_POL: pol_reg <= shreg;
                `IOX_CMD_CFG: cfg_reg <= shreg;
                default: ;                                // see (R20)
              endcase
            end
          end
        end
        SS_WACK: begin
          drv    <= 1'b0;
          bitcnt <= 4'h0;
          st     <= SS_WR;
        end
        SS_RD: begin
          if (bitcnt == `IOX_BYTE_BITS) begin
            drv <= 1'b0;
            st  <= SS_RACK;
          end else begin
            drv    <= ~txsh[7];                           // see (R05)
            txsh   <= {txsh[6:0], 1'b0};
            bitcnt <= bitcnt + 4'h1;
          end
        end
        SS_RACK: begin
          if (ack_in) begin
            txsh   <= {reg_rd[6:0], 1'b0};
            drv    <= ~reg_rd[7];
            bitcnt <= 4'h1;
            st     <= SS_RD;
          end else begin
            drv <= 1'b0;                                  // see (R15)
            st  <= SS_IDLE;
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out <= `IOX_OUT_RST;
      pin_oe  <= ~`IOX_CFG_RST;
    end else begin
      pin_out <= out_reg;
      pin_oe  <= ~cfg_reg;                                // see (R21)
    end
  end

  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = drv;

endmodule

//--- sim/iox_link_props.sv
// Purpose: link checks between the expander master and slave ends
// Assumes: SCL quarter period of at least 10 hclk
// Notes:   sees the resolved wires and the enables of iox_bus_if
`timescale 1ns/10ps
module iox_link_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------
  // Bus conditions
  // ----------------
  logic scl_q, sda_q, sta, stp;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  assign sta = scl & scl_q & sda_q & ~sda;
  assign stp = scl & scl_q & ~sda_q & sda;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------
  // Assertions
  // ----------------
  a_slave_data_hold: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave changed SDA while SCL high");
  a_slave_late_change: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("slave SDA change too close to SCL fall");
  a_quiet_after_stop: assert property (stp |=> !s_sda_oe [*8])
    else $error("slave drives SDA after STOP");
  a_scl_low_min: assert property ($fell(scl) |=> !scl [*8])
    else $error("SCL low phase too short");
  a_scl_high_min: assert property ($rose(scl) |=> scl [*8])
    else $error("SCL high phase too short");
  a_start_hold: assert property (sta |-> scl [*8])
    else $error("SCL fell too soon after START");
  a_scl_low_bound: assert property ($fell(scl) |-> ##[1:60] scl)
    else $error("SCL held low too long");
  a_stop_idle: assert property (stp |=> (scl && sda) [*8])
    else $error("bus not idle after STOP");
  a_master_sda_cond: assert property ($changed(m_sda_oe) && scl |-> sta || stp)
    else $error("master changed SDA while SCL high outside START or STOP");

  c_start: cover property (sta);
  c_slave_ack: cover property ($rose(s_sda_oe));
  c_stop: cover property (stp);
endmodule

//--- sim/testbench.sv
// Purpose: drives both link ends through the master's AHB-Lite registers
// Assumes: SCL period cut to 320 ns, so a quarter is 10 hclk
// Notes:   every transfer is started through CTRL and polled on STAT
`timescale 1ns/10ps
`include "iox_params.svh"
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        addr_strap, sup_rise, sup_fall;
  logic [31:0] haddr, hwdata, hrdata, rv, st;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  pin_in, pin_out, pin_oe;
  logic [7:0]  wv [4] = '{8'h00, 8'h3C, 8'hFF, 8'h0F};
  logic [7:0]  dv [4] = '{8'hA5, 8'hFF, 8'h00, 8'hFF};
  int          errors, compares;
  wire         hready = hreadyout;

  iox_bus_if link ();
  iox_master #(.SCL_PERIOD_NS(320)) u_iox_master (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(link));
  iox_slave u_iox_slave (.hclk(hclk), .hresetn(hresetn), .bus(link), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .addr_strap(addr_strap),
    .port_supply_above_rise(sup_rise), .port_supply_below_fall(sup_fall));
  iox_link_props u_props (.hclk(hclk), .hresetn(hresetn), .m_scl_o(link.m_scl_o),
    .m_scl_oe(link.m_scl_oe), .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe),
    .s_sda_o(link.s_sda_o), .s_sda_oe(link.s_sda_oe), .scl(link.scl), .sda(link.sda));

  initial begin
    hclk = 1'h0;
    forever #4 hclk = ~hclk;
  end

  // ----------------
  // Tasks
  // ----------------
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 100);
    if (hready !== 1'h1) begin
      errors++;
      end_of_test();
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  // Busy is polled rather than timed, the bit period is the master's business
  task automatic xfer(input logic [6:0] sla, input logic [7:0] cmd, input logic [7:0] dat,
                      input logic [2:0] ctl);
    int n;
    ahb(1'h1, `IOX_REG_SLA, {25'h0, sla}, rv);
    ahb(1'h1, `IOX_REG_CMD, {24'h0, cmd}, rv);
    ahb(1'h1, `IOX_REG_DATA, {24'h0, dat}, rv);
    ahb(1'h1, `IOX_REG_CTRL, {29'h0, ctl}, rv);
    n = 0;
    do begin
      ahb(1'h0, `IOX_REG_STAT, 32'h0, st);
      n++;
    end while (st[0] !== 1'h0 && n < 3000);
    if (st[0] !== 1'h0) begin
      errors++;
      end_of_test();
    end
    ahb(1'h0, `IOX_REG_DATA, 32'h0, rv);
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    errors = 0;
    compares = 0;
    hresetn <= 1'h0;
    hsel <= 1'h1;
    hsize <= 3'h2;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'h0;
    hwdata <= 32'h0;
    pin_in <= 8'hA5;
    addr_strap <= 1'h0;
    sup_rise <= 1'h1;
    sup_fall <= 1'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (6) @(posedge hclk);
    check(pin_out, 8'hFF);
    check(pin_oe, 8'h00);
    for (int i = 0; i < 4; i++) begin
      xfer(7'h20, 8'(i), 8'h00, 3'h3);
      check(rv[7:0], dv[i]);
    end
    $display("reset defaults done");
    for (int i = 1; i < 4; i++) begin
      xfer(7'h20, 8'(i), wv[i], 3'h1);
      xfer(7'h20, 8'(i), 8'h00, 3'h3);
      check(rv[7:0], wv[i]);
    end
    check(pin_out, 8'h3C);
    check(pin_oe, 8'hF0);
    xfer(7'h20, 8'h00, 8'h12, 3'h1);
    xfer(7'h20, 8'h00, 8'h00, 3'h3);
    check(rv[7:0], 8'h5A);
    xfer(7'h20, 8'h04, 8'h77, 3'h1);
    check({6'h0, st[1:0]}, 8'h00);
    xfer(7'h20, 8'h04, 8'h00, 3'h3);
    check(rv[7:0], 8'h00);
    xfer(7'h20, 8'h01, 8'h00, 3'h3);
    xfer(7'h20, 8'h00, 8'h00, 3'h7);
    check(rv[7:0], 8'h3C);
    $display("register writes done");
    for (int i = 0; i < 4; i++) begin
      addr_strap <= i[1];
      xfer(7'h20 | 7'(i[0]), 8'h01, 8'h00, 3'h3);
      check({6'h0, st[1:0]}, {6'h0, i[0] ^ i[1], 1'h0});
    end
    addr_strap <= 1'h0;
    $display("address strap done");
    sup_rise <= 1'h0;
    repeat (10) @(posedge hclk);
    sup_rise <= 1'h1;
    repeat (10) @(posedge hclk);
    check(pin_out, 8'h3C);
    sup_fall <= 1'h1;
    sup_rise <= 1'h0;
    repeat (10) @(posedge hclk);
    check(pin_out, 8'hFF);
    xfer(7'h20, 8'h01, 8'h00, 3'h3);
    check({6'h0, st[1:0]}, 8'h02);
    sup_fall <= 1'h0;
    sup_rise <= 1'h1;
    repeat (8) @(posedge hclk);
    xfer(7'h20, 8'h00, 8'h00, 3'h7);
    check(rv[7:0], 8'hA5);
    $display("power-on reset done");
    ahb(1'h1, 8'h14, 32'h5A, rv);
    ahb(1'h0, 8'h14, 32'h0, rv);
    check(rv[7:0], 8'h00);
    check({7'h0, hresp}, 8'h00);
    $display("unmapped access done");
    end_of_test();
  end
endmodule
